// *** src/scan_map.svh ***
// constants for the boundary-scan test access block
// assumes inclusion by the package, the pin cells, the tap and the bench
`ifndef SCAN_MAP_SVH
`define SCAN_MAP_SVH
`define INSTR_W 4
`define INSTR_EXTEST 4'h0
`define INSTR_SAMPLE 4'h1
`define INSTR_IDCODE 4'h2
`define INSTR_CLAMP 4'h3
`define INSTR_HIGHZ 4'h4
`define INSTR_BYPASS 4'hF
`define INSTR_CAPTURE 4'h1
`define ID_W 32
`define ID_VER_LSB 28
`define ID_PART_LSB 12
`define ID_VENDOR_LSB 1
`define ID_MARK_BIT 0
`define FUNC_IN_W 8
`define FUNC_OUT_W 8
`define CHAIN_W 16
`define CELL_OUT_LSB 8
`endif

// *** src/scan_pkg.sv ***
// types for the boundary-scan test access block
// assumes scan_map.svh is on the include path
`include "scan_map.svh"
package scan_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;
    typedef enum logic [1:0] {
        PATH_BYPASS, PATH_ID, PATH_CHAIN
    } path_t;
    // pins seen by the test port
    typedef struct packed {
        logic tms;
        logic tdi;
    } test_in_t;
    // instruction decode seen by the core domain
    typedef struct packed {
        logic drive_cells;
        logic float_outs;
    } pin_mode_t;
endpackage

// *** src/level_sync.sv ***
// two-flop synchroniser for a bundle of levels
// assumes the destination clock is clk and the source is asynchronous
`timescale 1ns/10ps
module level_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // =====================================================
    // next values: hold while clock enable is low
    always_comb begin
        meta_d = ce ? async_in : meta_q;
        sync_d = ce ? meta_q : sync_q;
    end

    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// *** src/pin_cells.sv ***
// functional pin boundary cells in the core clock domain
// assumes the test-domain chain is the cell content source
`timescale 1ns/10ps
`include "scan_map.svh"
module pin_cells (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire scan_pkg::pin_mode_t mode,
    input wire logic [`FUNC_OUT_W-1:0] cell_out,
    input wire logic [`FUNC_OUT_W-1:0] core_out,
    input wire logic [`FUNC_OUT_W-1:0] core_oe,
    output logic [`FUNC_OUT_W-1:0] pin_out,
    output logic [`FUNC_OUT_W-1:0] pin_oe
);
    logic [`FUNC_OUT_W-1:0] out_q;
    logic [`FUNC_OUT_W-1:0] out_d;
    logic [`FUNC_OUT_W-1:0] oe_q;
    logic [`FUNC_OUT_W-1:0] oe_d;

    // =====================================================
    // output mux: float, cells, or core
    always_comb begin
        out_d = out_q;
        oe_d = oe_q;
        if (ce) begin
            if (mode.float_outs) begin
                out_d = '0;
                oe_d = '0; // RULE4
            end else if (mode.drive_cells) begin
                out_d = cell_out; // RULE1
                oe_d = '1;
            end else begin
                out_d = core_out;
                oe_d = core_oe;
            end
        end
    end

    // registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            out_q <= '0;
            oe_q <= '0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe = oe_q;

    a_float_outs: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && mode.float_outs |=> pin_oe == '0) // RULE4
        else $error("outputs not floated");
endmodule

// *** src/scan_tap.sv ***
// boundary-scan test access port with instruction, bypass, id and chain
// assumes tck is the test clock from the tester, mclk the core clock
// Overview of operation
// RULE1 - extest drives cells, chain in path
// RULE2 - bypass puts one bit in path
// RULE3 - idcode loads and shifts id value
// RULE4 - highz floats outputs, bypass in path
// RULE5 - clamp drives cells, bypass in path
// RULE6 - sample captures pins into chain
// RULE7 - preload shifts bits into chain cells
// RULE8 - tester uses only six defined codes
// RULE9 - id holds version, part, vendor fields
// RULE10 - id bit zero always one
// RULE11 - chain covers all functional inputs
// RULE12 - chain covers all functional outputs
// RULE13 - tester runs test clock at 10MHz; the tester model runs it at 12.5MHz, 80 ns period
// RULE14 - no scan test during sleep
// RULE15 - sixteen-state controller, async test reset
// RULE16 - instruction captured, shifted lsb first, updated
`timescale 1ns/10ps
`include "scan_map.svh"
module scan_tap #(
    parameter logic [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [15:0] ID_PART = 16'hA5A5, // arbitrary value
    parameter logic [10:0] ID_VENDOR = 11'h155 // arbitrary value
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [`FUNC_IN_W-1:0] func_in,
    input wire logic [`FUNC_OUT_W-1:0] core_out,
    input wire logic [`FUNC_OUT_W-1:0] core_oe,
    output logic [`FUNC_OUT_W-1:0] pin_out,
    output logic [`FUNC_OUT_W-1:0] pin_oe
);
    scan_pkg::tap_state_t st_q;
    scan_pkg::tap_state_t st_d;
    scan_pkg::test_in_t tin;
    logic [`INSTR_W-1:0] ir_sh_q;
    logic [`INSTR_W-1:0] ir_sh_d;
    logic [`INSTR_W-1:0] test_instruction_reg_q;
    logic [`INSTR_W-1:0] test_instruction_reg_d;
    logic single_bit_pass_reg_q;
    logic single_bit_pass_reg_d;
    logic [`ID_W-1:0] part_code_reg_q;
    logic [`ID_W-1:0] part_code_reg_d;
    logic [`CHAIN_W-1:0] pin_cell_chain_q;
    logic [`CHAIN_W-1:0] pin_cell_chain_d;
    logic [`CHAIN_W-1:0] cell_upd_q;
    logic [`CHAIN_W-1:0] cell_upd_d;
    logic tdo_q;
    logic tdo_d;
    logic oe_q;
    logic oe_d;
    logic [`CHAIN_W-1:0] pin_samp;
    logic upd_tog_q;
    logic upd_tog_d;
    logic tog_s;
    logic tog_seen_q;
    logic tog_seen_d;
    logic [`FUNC_OUT_W-1:0] cell_hold_q;
    logic [`FUNC_OUT_W-1:0] cell_hold_d;
    logic [1:0] mode_raw;
    logic [1:0] mode_s;
    scan_pkg::pin_mode_t mode;
    scan_pkg::path_t path;

    // fixed identification value, mark bit set
    localparam logic [`ID_W-1:0] ID_VALUE =
        {ID_VERSION, ID_PART, ID_VENDOR, 1'b1}; // RULE9 RULE10

    // path selection from the active instruction
    function automatic scan_pkg::path_t sel_path(
        input logic [`INSTR_W-1:0] ins
    );
        if (ins == `INSTR_EXTEST || ins == `INSTR_SAMPLE) begin
            sel_path = scan_pkg::PATH_CHAIN; // RULE1 RULE6
        end else if (ins == `INSTR_IDCODE) begin
            sel_path = scan_pkg::PATH_ID; // RULE3
        end else begin
            sel_path = scan_pkg::PATH_BYPASS; // RULE2 RULE4 RULE5
        end
    endfunction

    assign tin = '{tms: tms, tdi: tdi};
    assign path = sel_path(test_instruction_reg_q);

    // =====================================================
    // output pins and input pins sampled into the test domain
    level_sync #(.W(`CHAIN_W)) u_out_sync (
        .clk(tck),
        .rst(~trst_n),
        .ce(1'b1),
        .async_in({pin_out, func_in}),
        .sync_out(pin_samp)
    );

    // controller next state
    always_comb begin
        st_d = st_q;
        case (st_q) // RULE15
            scan_pkg::TLR: st_d = tin.tms ? scan_pkg::TLR : scan_pkg::RTI;
            scan_pkg::RTI: st_d = tin.tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
            scan_pkg::SEL_DR:
                st_d = tin.tms ? scan_pkg::SEL_IR : scan_pkg::CAP_DR;
            scan_pkg::CAP_DR:
                st_d = tin.tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
            scan_pkg::SH_DR:
                st_d = tin.tms ? scan_pkg::EX1_DR : scan_pkg::SH_DR;
            scan_pkg::EX1_DR:
                st_d = tin.tms ? scan_pkg::UPD_DR : scan_pkg::PA_DR;
            scan_pkg::PA_DR:
                st_d = tin.tms ? scan_pkg::EX2_DR : scan_pkg::PA_DR;
            scan_pkg::EX2_DR:
                st_d = tin.tms ? scan_pkg::UPD_DR : scan_pkg::SH_DR;
            scan_pkg::UPD_DR:
                st_d = tin.tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
            scan_pkg::SEL_IR:
                st_d = tin.tms ? scan_pkg::TLR : scan_pkg::CAP_IR;
            scan_pkg::CAP_IR:
                st_d = tin.tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
            scan_pkg::SH_IR:
                st_d = tin.tms ? scan_pkg::EX1_IR : scan_pkg::SH_IR;
            scan_pkg::EX1_IR:
                st_d = tin.tms ? scan_pkg::UPD_IR : scan_pkg::PA_IR;
            scan_pkg::PA_IR:
                st_d = tin.tms ? scan_pkg::EX2_IR : scan_pkg::PA_IR;
            scan_pkg::EX2_IR:
                st_d = tin.tms ? scan_pkg::UPD_IR : scan_pkg::SH_IR;
            scan_pkg::UPD_IR:
                st_d = tin.tms ? scan_pkg::SEL_DR : scan_pkg::RTI;
            default: st_d = scan_pkg::TLR;
        endcase
    end

    // instruction shift and update
    always_comb begin
        ir_sh_d = ir_sh_q;
        test_instruction_reg_d = test_instruction_reg_q;
        if (st_q == scan_pkg::TLR) begin
            test_instruction_reg_d = `INSTR_IDCODE;
        end else if (st_q == scan_pkg::CAP_IR) begin
            ir_sh_d = `INSTR_CAPTURE; // RULE16
        end else if (st_q == scan_pkg::SH_IR) begin
            ir_sh_d = {tin.tdi, ir_sh_q[`INSTR_W-1:1]}; // RULE16
        end else if (st_q == scan_pkg::UPD_IR) begin
            test_instruction_reg_d = ir_sh_q; // RULE16
        end
    end

    // data registers: bypass, id, pin cells
    always_comb begin
        single_bit_pass_reg_d = single_bit_pass_reg_q;
        part_code_reg_d = part_code_reg_q;
        pin_cell_chain_d = pin_cell_chain_q;
        cell_upd_d = cell_upd_q;
        upd_tog_d = upd_tog_q;
        if (st_q == scan_pkg::CAP_DR) begin
            single_bit_pass_reg_d = 1'b0;
            part_code_reg_d = ID_VALUE; // RULE3
            pin_cell_chain_d = pin_samp; // RULE6 RULE11 RULE12
        end else if (st_q == scan_pkg::SH_DR) begin
            single_bit_pass_reg_d = tin.tdi; // RULE2
            part_code_reg_d = {tin.tdi, part_code_reg_q[`ID_W-1:1]};
            if (path == scan_pkg::PATH_CHAIN) begin
                pin_cell_chain_d =
                    {tin.tdi, pin_cell_chain_q[`CHAIN_W-1:1]}; // RULE7
            end
        end else if (st_q == scan_pkg::UPD_DR &&
                path == scan_pkg::PATH_CHAIN) begin
            cell_upd_d = pin_cell_chain_q; // RULE7
            upd_tog_d = ~upd_tog_q;
        end
    end

    // serial output, changes on falling edge
    always_comb begin
        tdo_d = tdo_q;
        oe_d = (st_q == scan_pkg::SH_DR) || (st_q == scan_pkg::SH_IR);
        if (st_q == scan_pkg::SH_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (path == scan_pkg::PATH_CHAIN) begin
            tdo_d = pin_cell_chain_q[0];
        end else if (path == scan_pkg::PATH_ID) begin
            tdo_d = part_code_reg_q[0];
        end else begin
            tdo_d = single_bit_pass_reg_q;
        end
    end

    // test-domain registers, async test reset
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            st_q <= scan_pkg::TLR; // RULE15
            ir_sh_q <= '0;
            test_instruction_reg_q <= `INSTR_IDCODE;
            single_bit_pass_reg_q <= 1'b0;
            part_code_reg_q <= '0;
            pin_cell_chain_q <= '0;
            cell_upd_q <= '0;
            upd_tog_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ir_sh_q <= ir_sh_d;
            test_instruction_reg_q <= test_instruction_reg_d;
            single_bit_pass_reg_q <= single_bit_pass_reg_d;
            part_code_reg_q <= part_code_reg_d;
            pin_cell_chain_q <= pin_cell_chain_d;
            cell_upd_q <= cell_upd_d;
            upd_tog_q <= upd_tog_d;
        end
    end

    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            oe_q <= oe_d;
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = oe_q;

    // =====================================================
    // instruction mode and cell values crossed to the core clock
    assign mode_raw = {
        (test_instruction_reg_q == `INSTR_EXTEST) ||
            (test_instruction_reg_q == `INSTR_CLAMP), // RULE1 RULE5
        test_instruction_reg_q == `INSTR_HIGHZ}; // RULE4

    level_sync #(.W(2)) u_mode_sync (
        .clk(mclk),
        .rst(sys_rst),
        .ce(ce),
        .async_in(mode_raw),
        .sync_out(mode_s)
    );

    // update toggle crossed; the cell word has settled before it shows
    level_sync #(.W(1)) u_tog_sync (
        .clk(mclk),
        .rst(sys_rst),
        .ce(ce),
        .async_in(upd_tog_q),
        .sync_out(tog_s)
    );

    // cell word taken once per toggle, never while it moves
    always_comb begin
        tog_seen_d = ce ? tog_s : tog_seen_q;
        cell_hold_d = cell_hold_q;
        if (ce && tog_s != tog_seen_q) begin
            cell_hold_d = cell_upd_q[`CHAIN_W-1:`CELL_OUT_LSB];
        end
    end

    // registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {tog_seen_q, cell_hold_q} <= '0;
        end else begin
            {tog_seen_q, cell_hold_q} <= {tog_seen_d, cell_hold_d};
        end
    end

    assign mode = '{drive_cells: mode_s[1], float_outs: mode_s[0]};

    pin_cells u_cells (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .mode(mode),
        .cell_out(cell_hold_q),
        .core_out(core_out),
        .core_oe(core_oe),
        .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // =====================================================
    a_ir_update: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::UPD_IR |=>
        test_instruction_reg_q == $past(ir_sh_q)) // RULE16
        else $error("instruction not updated");

    a_ir_capture: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::CAP_IR |=> ir_sh_q == `INSTR_CAPTURE) // RULE16
        else $error("instruction capture wrong");

    a_id_load: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::CAP_DR |=> part_code_reg_q[0] == 1'b1 &&
        part_code_reg_q[31:28] == ID_VERSION) // RULE9 RULE10
        else $error("id value wrong");

    a_tms_reset: assert property (@(posedge tck) disable iff (!trst_n)
        tms [*5] |=> st_q == scan_pkg::TLR) // RULE15
        else $error("five tms highs did not reset");

    a_bypass_path: assert property (@(posedge tck) disable iff (!trst_n)
        test_instruction_reg_q == `INSTR_BYPASS && st_q == scan_pkg::SH_DR |->
        tdo == single_bit_pass_reg_q) // RULE2
        else $error("bypass path wrong");

    a_clamp_path: assert property (@(posedge tck) disable iff (!trst_n)
        test_instruction_reg_q == `INSTR_CLAMP && st_q == scan_pkg::SH_DR |->
        tdo == single_bit_pass_reg_q && mode_raw == 2'b10) // RULE5
        else $error("clamp decode wrong");

    a_id_shift: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::SH_DR ##1 st_q == scan_pkg::SH_DR |->
        part_code_reg_q[30:0] == $past(part_code_reg_q[31:1])) // RULE3
        else $error("id not shifted");

    a_chain_shift: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::SH_DR && path == scan_pkg::PATH_CHAIN |=>
        pin_cell_chain_q[15] == $past(tdi)) // RULE7
        else $error("chain did not take tdi");

    a_drive_cells: assert property (@(posedge mclk) disable iff (sys_rst)
        ce && mode.drive_cells && !mode.float_outs |=>
        pin_out == $past(cell_hold_q)) // RULE1
        else $error("cells not driven");

    a_sample_cap: assert property (@(posedge tck) disable iff (!trst_n)
        st_q == scan_pkg::CAP_DR |=>
        pin_cell_chain_q[7:0] == $past(pin_samp[7:0])) // RULE6 RULE11
        else $error("inputs not captured");
endmodule

// *** sim/scan_tester.sv ***
// test controller model driving the serial test port
// assumes the test clock stands low outside scans, 80 ns period
`timescale 1ns/10ps
module scan_tester (
    output logic tck,
    output logic trst_n,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ==========================================================
    // idle levels
    // pins quiet and test reset held until released
    initial begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ==========================================================
    // one test clock period
    // pins change after the fall, tdo taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #40;
        tck = 1'b1;
        o = tdo;
        #40;
        tck = 1'b0;
    endtask

    // pulse test reset, then walk into run-test-idle
    task automatic treset();
        logic o;
        trst_n = 1'b0;
        #100;
        trst_n = 1'b1;
        #40;
        step(1'b0, ~tdi, o);
    endtask

    // ==========================================================
    // ir or dr scan from run-test-idle back to idle
    // callers pass only defined codes; no sleep port exists here
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        step(1'b1, ~tdi, o);
        if (ir) begin
            step(1'b1, ~tdi, o);
        end
        step(1'b0, ~tdi, o);
        step(1'b0, ~tdi, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, ~tdi, o);
        // idle spell lets pin changes settle
        repeat (5) step(1'b0, ~tdi, o);
    endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench for the boundary-scan test access block
// assumes scan_tap and scan_tester compiled, scan_map.svh included
`timescale 1ns/10ps
`include "scan_map.svh"
module tb;
    localparam logic [31:0] ID = {4'h1, 16'hA5A5, 11'h155, 1'b1};
    localparam logic [31:0] PAT = 32'hB6C3_9A71;
    typedef struct {
        logic [3:0] code;
        int len;
        logic [31:0] cap;
        logic [7:0] pout;
        logic [7:0] poe;
    } row_t;
    logic mclk, sys_rst, ce, tck, trst_n, tms, tdi, tdo, tdo_oe, o;
    logic tdo_line;
    logic [7:0] func_in, core_out, core_oe, pin_out, pin_oe;
    logic [31:0] d;
    int failures = 0;
    int checked = 0;
    row_t rows [6] = '{
        '{`INSTR_SAMPLE, 16, 32'h3C5A, 8'h3C, 8'hF0},
        '{`INSTR_EXTEST, 16, 32'hB65A, 8'hB6, 8'hFF},
        '{`INSTR_CLAMP, 1, 32'h0, 8'hB6, 8'hFF},
        '{`INSTR_HIGHZ, 1, 32'h0, 8'h00, 8'h00},
        '{`INSTR_BYPASS, 1, 32'h0, 8'h3C, 8'hF0},
        '{`INSTR_IDCODE, 32, ID, 8'h3C, 8'hF0}};

    // ==========================================================
    // instances
    scan_tap #(.ID_VERSION(4'h1), .ID_PART(16'hA5A5),
               .ID_VENDOR(11'h155)) i_dut (
        .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .tck(tck),
        .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .func_in(func_in), .core_out(core_out),
        .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
    scan_tester i_tester (.tck(tck), .trst_n(trst_n), .tms(tms),
                          .tdi(tdi), .tdo(tdo_line));
    // a released serial output reads inverted at the tester
    assign tdo_line = tdo_oe ? tdo : ~tdo;

    // ==========================================================
    // clock, watchdog, helpers
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;

    initial begin
        #300000;
        failures++;
        end_of_test();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // captured bits first, then the pattern delayed by path length
    function automatic logic [31:0] expw(input int len,
                                         input logic [31:0] cap);
        logic [63:0] w;
        w = {32'h0, PAT} << len;
        w = w | {32'h0, cap};
        return w[31:0];
    endfunction

    task automatic end_of_test();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        ce = 1'b1;
        func_in = 8'h5A;
        core_out = 8'h3C;
        core_oe = 8'hF0;
        sys_rst = 1'b1;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        i_tester.treset();
        // instruction table: ir capture, path length, pin effect
        foreach (rows[i]) begin
            i_tester.scan(1'b1, 4, {28'h0, rows[i].code}, d);
            check(d[3:0], `INSTR_CAPTURE);
            i_tester.scan(1'b0, 32, PAT, d);
            check(d, expw(rows[i].len, rows[i].cap));
            repeat (10) @(negedge mclk);
            check(pin_out, rows[i].pout);
            check(pin_oe, rows[i].poe);
            $display("test code %h done", rows[i].code);
        end
        // five mode-select highs return to idcode
        i_tester.scan(1'b1, 4, 32'hF, d);
        repeat (5) i_tester.step(1'b1, 1'b0, o);
        i_tester.step(1'b0, 1'b1, o);
        i_tester.scan(1'b0, 32, 32'h0, d);
        check(d, ID);
        $display("test tms reset done");
        // async test reset in mid-run while outputs float
        i_tester.scan(1'b1, 4, 32'h4, d);
        repeat (10) @(negedge mclk);
        check(pin_oe, 8'h00);
        i_tester.treset();
        repeat (10) @(negedge mclk);
        check(pin_oe, 8'hF0);
        check(tdo_oe, 1'b0);
        $display("test trst done");
        // core clock enable low freezes the pins
        @(posedge mclk);
        ce <= 1'b0;
        core_out <= 8'h81;
        repeat (10) @(negedge mclk);
        check(pin_out, 8'h3C);
        @(posedge mclk);
        ce <= 1'b1;
        repeat (10) @(negedge mclk);
        check(pin_out, 8'h81);
        $display("test clock enable done");
        // core reset in mid-run with outputs passing through
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        check({pin_out, pin_oe}, 16'h0);
        @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (10) @(negedge mclk);
        check(pin_out, 8'h81);
        $display("test core reset done");
        end_of_test();
    end
endmodule
